// file: design/e1_tx_sys_pkg.sv
// Shared constants for the E1 transmit backplane port of one framer.
// Assumes a 125 MHz core clock and a plain address/strobe register port.
package e1_tx_sys_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LAST = 8'h0c;

  // ==========================================================================
  // Control field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FRAME_EDGE = 2;
  localparam int CTRL_DATA_EDGE = 3;
  localparam int CTRL_FP_EDGE = 4;
  localparam int CTRL_RATE = 5;
  localparam int CTRL_PICK = 6;
  localparam int CTRL_POLARITY = 7;
  localparam int CTRL_BUS = 8;
  localparam int CTRL_CCS = 9;
  localparam int CTRL_SIGNALING_SOURCE_SEL = 10;
  localparam int CTRL_REF_B = 11;
  localparam int CTRL_WIDTH = 12;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [6:0] OFFSET_RESET = 7'h00;

  // ==========================================================================
  // Operating modes and framing figures.
  typedef enum logic [1:0] {
    MODE_SLAVE_EXT_SIG,
    MODE_CLOCK_MASTER,
    MODE_MULTIPLEXED,
    MODE_UNUSED
  } tx_mode_t;

  localparam logic [9:0] BITS_PER_FRAME = 10'h100;
  localparam logic [9:0] BITS_PER_MUX_FRAME = 10'h400;
  localparam logic [4:0] SIGNALING_SLOT = 5'h10;
  localparam int SYNC_STAGES = 2;

endpackage : e1_tx_sys_pkg

// file: design/e1_tx_sys_port.sv
// Transmit system-side port of one E1 framer: slave external signaling, clock master, multiplexed.
// Assumes all link clocks and link data come from outside the core clock domain and are slower
// than a quarter of the core clock rate; the other framers' rate and edge-pick bits arrive on core timing.
`timescale 1ns/1ns

module e1_tx_sys_port (
  // Core clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Other framers' rate and edge-pick bits, ORed.
  input wire logic i_any_rate_sel_other,
  input wire logic i_any_edge_pick_other,
  // System-side clocks.
  input wire logic i_sys_ref_clock_a,
  input wire logic i_sys_common_clock_b,
  input wire logic i_line_tx_clock,
  input wire logic i_mux_common_clock,
  // Per-framer backplane pins.
  input wire logic i_common_frame_pulse,
  input wire logic i_tx_serial_data,
  input wire logic i_tx_signaling_in,
  output logic o_per_framer_frame_pulse,
  output logic o_per_framer_frame_pulse_oe,
  // Multiplexed buses.
  input wire logic i_mux_common_frame_pulse,
  input wire logic [1:0] i_mux_serial_data,
  input wire logic [1:0] i_mux_signaling_in,
  output logic o_mux_frame_pulse_out,
  // Jitter-loop reference clock.
  output logic o_jitter_ref_clk,
  // Received time slots.
  output logic o_ts_valid,
  output logic [4:0] o_ts_num,
  output logic [7:0] o_ts_byte,
  output logic [7:0] o_ts_sig
);

  localparam int NSYNC = 12;

  // ==========================================================================
  // Registers.
  logic [e1_tx_sys_pkg::CTRL_WIDTH-1:0] ctrl_ff;
  logic [6:0] offset_ff;
  e1_tx_sys_pkg::tx_mode_t mode;
  logic is_master;
  logic is_mux;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_ff <= e1_tx_sys_pkg::CTRL_RESET;
      offset_ff <= e1_tx_sys_pkg::OFFSET_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == e1_tx_sys_pkg::ADDR_CTRL) begin
        ctrl_ff <= i_reg_wdata[e1_tx_sys_pkg::CTRL_WIDTH-1:0];
      end
      if (i_reg_addr == e1_tx_sys_pkg::ADDR_OFFSET) begin
        offset_ff <= i_reg_wdata[6:0];
      end
    end
  end

  assign mode = e1_tx_sys_pkg::tx_mode_t'(ctrl_ff[e1_tx_sys_pkg::CTRL_MODE_LSB +: 2]);
  assign is_master = (mode == e1_tx_sys_pkg::MODE_CLOCK_MASTER);
  assign is_mux = (mode == e1_tx_sys_pkg::MODE_MULTIPLEXED);

  logic frame_edge_sel;
  logic data_edge_sel;
  logic frame_pulse_edge_sel;
  logic frame_pulse_polarity;
  logic mux_bus_select;
  logic common_channel_signaling;
  logic signaling_source_sel;
  logic ref_b_select;
  logic eff_rate;
  logic eff_pick;

  assign frame_edge_sel = ctrl_ff[e1_tx_sys_pkg::CTRL_FRAME_EDGE];
  assign data_edge_sel = ctrl_ff[e1_tx_sys_pkg::CTRL_DATA_EDGE];
  assign frame_pulse_edge_sel = ctrl_ff[e1_tx_sys_pkg::CTRL_FP_EDGE];
  assign frame_pulse_polarity = ctrl_ff[e1_tx_sys_pkg::CTRL_POLARITY];
  assign mux_bus_select = ctrl_ff[e1_tx_sys_pkg::CTRL_BUS];
  assign common_channel_signaling = ctrl_ff[e1_tx_sys_pkg::CTRL_CCS];
  assign signaling_source_sel = ctrl_ff[e1_tx_sys_pkg::CTRL_SIGNALING_SOURCE_SEL];
  assign ref_b_select = ctrl_ff[e1_tx_sys_pkg::CTRL_REF_B];
  // In mux mode a one in any framer forces the whole group, so a single stray bit cannot split the bus timing.
  assign eff_rate = ctrl_ff[e1_tx_sys_pkg::CTRL_RATE] | (is_mux & i_any_rate_sel_other);
  assign eff_pick = ctrl_ff[e1_tx_sys_pkg::CTRL_PICK] | (is_mux & i_any_edge_pick_other);

  // ==========================================================================
  // Input synchronisers: stage one feeds stage two only.
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] sync3_ff;

  assign pins_raw = {i_sys_ref_clock_a, i_sys_common_clock_b, i_line_tx_clock, i_mux_common_clock,
                     i_common_frame_pulse, i_tx_serial_data, i_tx_signaling_in, i_mux_common_frame_pulse,
                     i_mux_serial_data, i_mux_signaling_in};

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic clk_a_s;
  logic clk_b_s;
  logic line_clk_s;
  logic mux_clk_s;
  logic cfp_s;
  logic tsd_s;
  logic tsig_s;
  logic mfp_s;
  logic [1:0] msd_s;
  logic [1:0] msig_s;
  logic sel_clk_now;
  logic sel_clk_prev;

  assign {clk_a_s, clk_b_s, line_clk_s, mux_clk_s, cfp_s, tsd_s, tsig_s, mfp_s, msd_s, msig_s} = sync2_ff;

  // Slave uses common clock B, master its line clock, mux the mux clock.
  always_comb begin
    case (mode)
      e1_tx_sys_pkg::MODE_CLOCK_MASTER: begin
        sel_clk_now = line_clk_s;
        sel_clk_prev = sync3_ff[9];
      end
      e1_tx_sys_pkg::MODE_MULTIPLEXED: begin
        sel_clk_now = mux_clk_s;
        sel_clk_prev = sync3_ff[8];
      end
      default: begin
        sel_clk_now = clk_b_s;
        sel_clk_prev = sync3_ff[10];
      end
    endcase
  end

  logic clk_rise;
  logic clk_fall;
  logic fe_evt;
  logic de_evt;
  logic fpe_evt;

  assign clk_rise = sel_clk_now & ~sel_clk_prev;
  assign clk_fall = ~sel_clk_now & sel_clk_prev;
  assign fe_evt = frame_edge_sel ? clk_rise : clk_fall;
  assign de_evt = data_edge_sel ? clk_rise : clk_fall;
  assign fpe_evt = frame_pulse_edge_sel ? clk_rise : clk_fall;

  // ==========================================================================
  // Frame pulse detection on the frame edge.
  logic fp_level;
  logic fp_prev_ff;
  logic fp_now;
  logic fp_pend_ff;

  assign fp_level = (is_mux ? mfp_s : cfp_s) ^ frame_pulse_polarity;
  // Only the first active edge of a pulse counts; a pulse spanning two edges at double rate is one frame.
  assign fp_now = fe_evt & fp_level & ~fp_prev_ff & ~is_master;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      fp_prev_ff <= 1'b0;
    end else if (fe_evt) begin
      fp_prev_ff <= fp_level;
    end
  end

  // ==========================================================================
  // Bit timing: a frame starts at the data edge at or after the frame edge.
  logic start;
  logic phase_ff;
  logic phase_now;
  logic take;
  logic [9:0] bit_pos_ff;
  logic [9:0] pos_now;
  logic [9:0] frame_bits;
  logic [9:0] pos_inc;
  logic [9:0] pos_next;

  // With equal selects both sample on one edge; otherwise the data edge follows one edge later.
  assign start = de_evt & (fp_pend_ff | (fp_now & (frame_edge_sel == data_edge_sel)));

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      fp_pend_ff <= 1'b0;
    end else if (start) begin
      fp_pend_ff <= 1'b0;
    end else if (fp_now) begin
      fp_pend_ff <= 1'b1;
    end
  end

  assign frame_bits = is_mux ? e1_tx_sys_pkg::BITS_PER_MUX_FRAME : e1_tx_sys_pkg::BITS_PER_FRAME;
  assign phase_now = start ? 1'b0 : phase_ff;
  assign take = de_evt & (~eff_rate | (phase_now == eff_pick));
  assign pos_now = start ? 10'h000 : bit_pos_ff;
  assign pos_inc = pos_now + 10'h001;
  assign pos_next = (pos_inc == frame_bits) ? 10'h000 : pos_inc;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      phase_ff <= 1'b0;
    end else if (de_evt) begin
      phase_ff <= eff_rate ? ~phase_now : 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      bit_pos_ff <= 10'h000;
    end else if (take) begin
      bit_pos_ff <= pos_next;
    end else if (start) begin
      bit_pos_ff <= 10'h000;
    end
  end

  logic locked_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      locked_ff <= 1'b0;
    end else if (start | is_master) begin
      locked_ff <= 1'b1;
    end
  end

  // ==========================================================================
  // Serial to byte, first bit of the slot into the top bit.
  logic data_bit;
  logic sig_bit;
  logic [7:0] data_sr_ff;
  logic [7:0] sig_sr_ff;
  logic [7:0] data_byte;
  logic [7:0] sig_byte;

  assign data_bit = is_mux ? msd_s[mux_bus_select] : tsd_s;
  // The shared pin is a signaling input except in master mode, where it drives the frame pulse.
  assign sig_bit = is_mux ? msig_s[mux_bus_select] : (tsig_s & ~is_master);
  assign data_byte = {data_sr_ff[6:0], data_bit};
  assign sig_byte = {sig_sr_ff[6:0], sig_bit};

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      data_sr_ff <= 8'h00;
      sig_sr_ff <= 8'h00;
    end else if (take) begin
      data_sr_ff <= data_byte;
      sig_sr_ff <= sig_byte;
    end
  end

  // ==========================================================================
  // Slot placement relative to the frame pulse.
  logic byte_done;
  logic [6:0] rel_slot;
  logic mine;
  logic [4:0] ts_num;
  logic sub_sig;

  assign byte_done = take & (pos_now[2:0] == 3'h7);
  assign rel_slot = is_master ? {2'b00, pos_now[7:3]} : (pos_now[9:3] - offset_ff);
  // A mux framer owns every fourth byte, the offset choosing which one.
  assign mine = ~is_mux | (rel_slot[1:0] == 2'b00);
  assign ts_num = is_mux ? rel_slot[6:2] : rel_slot[4:0];
  assign sub_sig = ~is_master & (ts_num == e1_tx_sys_pkg::SIGNALING_SLOT) & ~common_channel_signaling
                   & ~signaling_source_sel;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_ts_valid <= 1'b0;
      o_ts_num <= 5'h00;
      o_ts_byte <= 8'h00;
      o_ts_sig <= 8'h00;
    end else begin
      o_ts_valid <= byte_done & mine & locked_ff;
      // Bytes assembled before the first frame pulse are not shown, so the held byte only moves with valid.
      if (byte_done & mine & locked_ff) begin
        o_ts_num <= ts_num;
        o_ts_byte <= sub_sig ? sig_byte : data_byte;
        o_ts_sig <= sig_byte;
      end
    end
  end

  // ==========================================================================
  // Frame pulse outputs.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_per_framer_frame_pulse <= 1'b0;
      o_per_framer_frame_pulse_oe <= 1'b0;
    end else begin
      o_per_framer_frame_pulse_oe <= is_master;
      if (~is_master) begin
        o_per_framer_frame_pulse <= 1'b0;
      end else if (fpe_evt) begin
        o_per_framer_frame_pulse <= (bit_pos_ff == 10'h000);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_mux_frame_pulse_out <= 1'b0;
    end else if (~is_mux) begin
      o_mux_frame_pulse_out <= frame_pulse_polarity;
    end else if (take) begin
      o_mux_frame_pulse_out <= (pos_next == 10'h000) ^ frame_pulse_polarity;
    end
  end

  // ==========================================================================
  // Jitter-loop reference: the backplane clocks never time data in master mode.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_jitter_ref_clk <= 1'b0;
    end else if (is_master & ref_b_select) begin
      o_jitter_ref_clk <= clk_b_s;
    end else begin
      o_jitter_ref_clk <= clk_a_s;
    end
  end

  // ==========================================================================
  // Register read, data valid in the cycle after the strobe.
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_reg_addr)
      e1_tx_sys_pkg::ADDR_CTRL: rd_mux = {20'h00000, ctrl_ff};
      e1_tx_sys_pkg::ADDR_OFFSET: rd_mux = {25'h0000000, offset_ff};
      e1_tx_sys_pkg::ADDR_STATUS: rd_mux = {24'h000000, eff_pick, eff_rate, o_ts_num, locked_ff};
      e1_tx_sys_pkg::ADDR_LAST: rd_mux = {16'h0000, o_ts_sig, o_ts_byte};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : e1_tx_sys_port

// file: verif/e1_tx_sys_port_properties.sv
// Concurrent checks on the transmit backplane port of one framer.
// Assumes it is bound into e1_tx_sys_port and sees only that module's ports.
`timescale 1ns/1ns

module e1_tx_sys_port_properties (
  // Clock, reset and register port.
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_reg_rd,
  // Clocks and backplane outputs.
  input wire logic i_sys_ref_clock_a,
  input wire logic i_sys_common_clock_b,
  input wire logic o_per_framer_frame_pulse,
  input wire logic o_per_framer_frame_pulse_oe,
  input wire logic o_mux_frame_pulse_out,
  input wire logic o_jitter_ref_clk,
  input wire logic o_ts_valid,
  input wire logic [7:0] o_ts_byte
);
  // ==========================================================================
  // Shadow of the control register, rebuilt from the write strobes.
  logic [11:0] ctrl_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl_ff <= 12'h000;
    end else if (i_reg_wr && i_reg_addr == e1_tx_sys_pkg::ADDR_CTRL) begin
      ctrl_ff <= i_reg_wdata[11:0];
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // ==========================================================================
  // Assertions.
  sequence not_master;
    ctrl_ff[1:0] != 2'h1 && $past(ctrl_ff[1:0]) != 2'h1;
  endsequence
  a_pin_drive: assert property (
    i_reg_wr && i_reg_addr == e1_tx_sys_pkg::ADDR_CTRL && i_reg_wdata[1:0] == 2'h1
    |-> ##[1:3] o_per_framer_frame_pulse_oe) else $error("pin not driven in master mode");
  a_pin_input: assert property (not_master |=> !o_per_framer_frame_pulse_oe)
    else $error("pin driven outside master mode");
  a_pulse_idle: assert property (not_master |=> !o_per_framer_frame_pulse)
    else $error("frame pulse outside master mode");
  a_byte_gap: assert property (o_ts_valid |=> !o_ts_valid [*8])
    else $error("time slot bytes too close");
  a_byte_hold: assert property (!o_ts_valid ##1 !o_ts_valid |-> $stable(o_ts_byte))
    else $error("slot byte changed without valid");
  a_ref_mux: assert property ($rose(i_sys_ref_clock_a) && ctrl_ff[1:0] == 2'h2
    |-> ##[1:4] o_jitter_ref_clk) else $error("reference clock A not passed on");
  a_ref_master_b: assert property (
    $rose(i_sys_common_clock_b) && ctrl_ff[1:0] == 2'h1 && ctrl_ff[11]
    |-> ##[1:4] o_jitter_ref_clk) else $error("reference clock B not passed on");
  a_mux_fp_idle: assert property (ctrl_ff[1:0] != 2'h2 && $stable(ctrl_ff)
    |=> o_mux_frame_pulse_out == $past(ctrl_ff[7])) else $error("mux pulse active outside mux mode");
  a_rd_ctrl: assert property (i_reg_rd && i_reg_addr == e1_tx_sys_pkg::ADDR_CTRL
    |=> o_reg_rdata == {20'h00000, $past(ctrl_ff)}) else $error("control readback wrong");

  cover property (o_ts_valid);
  cover property ($rose(o_per_framer_frame_pulse_oe));
  cover property (ctrl_ff[1:0] == 2'h2 && o_mux_frame_pulse_out != ctrl_ff[7]);
endmodule : e1_tx_sys_port_properties

bind e1_tx_sys_port e1_tx_sys_port_properties chk (.i_ref_clk, .i_srst, .i_reg_addr, .i_reg_wdata,
  .i_reg_wr, .o_reg_rdata, .i_reg_rd, .i_sys_ref_clock_a, .i_sys_common_clock_b, .o_per_framer_frame_pulse,
  .o_per_framer_frame_pulse_oe, .o_mux_frame_pulse_out, .o_jitter_ref_clk, .o_ts_valid, .o_ts_byte);

// file: verif/e1_tx_backplane_model.sv
// Behavioural system-side TDM source: link clock, frame pulse, data and signaling.
// Assumes the port under test accepts a link clock that stands still between runs.
`timescale 1ns/1ns

module e1_tx_backplane_model (
  // Control from the bench.
  input wire logic i_run,
  input wire logic i_mux,
  input wire logic i_double,
  // Backplane lines.
  output logic o_clk,
  output logic o_frame,
  output logic o_data,
  output logic o_sig
);
  int bit_idx = -1;
  logic [7:0] slot;
  logic [7:0] d;
  logic [7:0] s;
  logic [2:0] pos;

  // ==========================================================================
  // One lead-in bit precedes each run so a falling edge exists before bit 1.
  always begin
    if (i_run) begin
      slot = (bit_idx < 0) ? 8'h00 : 8'(bit_idx / 8);
      pos = 3'(7 - bit_idx % 8);
      d = 8'h5a ^ slot;
      s = 8'hc3 ^ slot;
      o_clk = 1'b0;
      o_data = d[pos];
      o_sig = s[pos];
      if (bit_idx < 0) o_frame = 1'b0;
      // At double rate each bit spans two clock periods; the pulse moves only in the second one.
      if (i_double) begin
        #80 o_clk = 1'b1;
        #80 o_clk = 1'b0;
      end
      #80 o_clk = 1'b1;
      // The pulse moves mid-high, so falling and rising edges around bit 1 both see it.
      #40 o_frame = ((bit_idx + 1) % (i_mux ? 1024 : 256)) == 0;
      #40 bit_idx = (bit_idx + 1) % (i_mux ? 1024 : 256);
    end else begin
      bit_idx = -1;
      o_clk = 1'b0;
      o_data = (o_data === 1'b1) ? 1'b0 : 1'b1;
      o_sig = ~o_data;
      o_frame = o_data;
      #80;
    end
  end
endmodule : e1_tx_backplane_model

// file: verif/e1_tx_sys_port_tb.sv
// Self-checking bench for the transmit backplane port of one framer.
// Assumes the backplane model drives every link clock except clock A, which the bench drives, and every frame pulse and data line.
`timescale 1ns/1ns

module e1_tx_sys_port_tb;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rdata;} reg_row_t;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h00000000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] o_reg_rdata;
  logic rate_other = 1'b0;
  logic ref_a = 1'b0;
  logic run = 1'b0;
  logic mux = 1'b0;
  logic lclk, lfp, ld, ls, fp, fp_oe, mux_fp, jref, ts_valid, last_fp;
  logic [4:0] ts_num;
  logic [7:0] ts_byte, ts_sig;
  logic [31:0] rd;
  int errors = 0;
  int samples_checked = 0;
  int cnt, rises, cyc;
  reg_row_t rows [5] = '{'{8'h00, 32'hffffffff, 32'h00000fff}, '{8'h04, 32'hffffffff, 32'h0000007f},
    '{8'h10, 32'hffffffff, 32'h00000000}, '{8'h0c, 32'hffffffff, 32'h00000000},
    '{8'h00, 32'h00000000, 32'h00000000}};

  always #4 i_ref_clk = ~i_ref_clk;
  // A period of 192 ns keeps the edges of clock A off the core clock's rising edges.
  always #96 ref_a = ~ref_a;

  e1_tx_backplane_model far (.i_run(run), .i_mux(mux), .i_double(rate_other), .o_clk(lclk), .o_frame(lfp),
    .o_data(ld), .o_sig(ls));
  e1_tx_sys_port dut (.i_ref_clk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_any_rate_sel_other(rate_other), .i_any_edge_pick_other(rate_other), .i_sys_ref_clock_a(ref_a),
    .i_sys_common_clock_b(lclk), .i_line_tx_clock(lclk), .i_mux_common_clock(lclk),
    .i_common_frame_pulse(lfp), .i_tx_serial_data(ld), .i_tx_signaling_in(ls),
    .o_per_framer_frame_pulse(fp), .o_per_framer_frame_pulse_oe(fp_oe), .i_mux_common_frame_pulse(lfp),
    .i_mux_serial_data({~ld, ld}), .i_mux_signaling_in({~ls, ls}), .o_mux_frame_pulse_out(mux_fp),
    .o_jitter_ref_clk(jref), .o_ts_valid(ts_valid), .o_ts_num(ts_num), .o_ts_byte(ts_byte), .o_ts_sig(ts_sig));

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic reset_dut(input int n);
    i_srst <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : reset_dut

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
    @(posedge i_ref_clk);
  endtask : reg_rd

  // Bus 1 carries the inverted stream, so a wrong bus select shows in every byte.
  task automatic run_frame(input logic [11:0] ctrl, input logic [6:0] off, input int n);
    logic [7:0] slot, inv;
    logic [4:0] prev;
    int got;
    got = 0;
    cyc = 0;
    reset_dut(3);
    reg_wr(e1_tx_sys_pkg::ADDR_CTRL, {20'h00000, ctrl});
    reg_wr(e1_tx_sys_pkg::ADDR_OFFSET, {25'h0000000, off});
    mux = ctrl[1];
    run = 1'b1;
    inv = {8{ctrl[8] & ctrl[1]}};
    while (got < n && cyc < 30000) begin
      @(posedge i_ref_clk);
      #1 cyc++;
      if (ts_valid === 1'b1) begin
        slot = mux ? 8'((4 * ts_num + off) % 128) : 8'((ts_num + off) % 32);
        if (got > 0) check(32'(ts_num), 32'(5'(prev + 5'h01)));
        if (mux) check(32'(mux_fp ^ ctrl[7]), 32'(slot == 8'h7f));
        check(32'(ts_sig), 32'((8'hc3 ^ slot) ^ inv));
        check(32'(ts_byte), 32'(((ts_num == 5'h10 && !ctrl[9] && !ctrl[10]) ? 8'hc3 : 8'h5a) ^ slot ^ inv));
        prev = ts_num;
        got++;
      end
    end
    run = 1'b0;
    // Let the model finish its last bit and fall idle before the next reset.
    repeat (40) @(posedge i_ref_clk);
    if (got < n) begin
      errors++;
      print_verdict();
    end
  endtask : run_frame

  // ==========================================================================
  // Main sequence.
  initial begin
    reset_dut(20);
    check(32'({fp_oe, fp, ts_valid}), 32'h0);
    foreach (rows[i]) begin
      reg_wr(rows[i].addr, rows[i].wdata);
      reg_rd(rows[i].addr, rd);
      check(rd, rows[i].rdata);
    end
    reg_wr(e1_tx_sys_pkg::ADDR_CTRL, 32'h00000002);
    rate_other <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    reg_rd(e1_tx_sys_pkg::ADDR_STATUS, rd);
    check(32'(rd[7:6]), 32'h3);
    reg_wr(e1_tx_sys_pkg::ADDR_CTRL, 32'h00000000);
    reg_rd(e1_tx_sys_pkg::ADDR_STATUS, rd);
    check(32'(rd[7:6]), 32'h0);
    rate_other <= 1'b0;
    run_frame(12'h00c, 7'h03, 33);
    run_frame(12'h208, 7'h00, 33);
    run_frame(12'h10e, 7'h03, 33);
    rate_other <= 1'b1;
    run_frame(12'h00e, 7'h02, 9);
    rate_other <= 1'b0;
    reset_dut(3);
    reg_wr(e1_tx_sys_pkg::ADDR_CTRL, 32'h00000819);
    run = 1'b1;
    cnt = 0;
    rises = 0;
    cyc = 0;
    last_fp = 1'b0;
    while (rises < 2 && cyc < 30000) begin
      @(posedge i_ref_clk);
      #1 cyc++;
      if (rises == 1 && ts_valid === 1'b1) cnt++;
      if (fp === 1'b1 && last_fp === 1'b0) rises++;
      last_fp = fp;
    end
    if (rises < 2) errors++;
    check(32'(cnt), 32'd32);
    check(32'(fp_oe), 32'h1);
    run = 1'b0;
    print_verdict();
  end
endmodule : e1_tx_sys_port_tb
